// ---- rtl/pcc_pkg.sv ----
package pcc_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [7:0]  PCC_OFF_COUNT  = 8'h00;
    localparam logic [7:0]  PCC_OFF_CTRL   = 8'h04;
    localparam logic [7:0]  PCC_OFF_HILIM  = 8'h08;
    localparam logic [7:0]  PCC_OFF_LOLIM  = 8'h0c;
    localparam logic [7:0]  PCC_OFF_ALARM  = 8'h10;
    // ------------------------------------------------------------
    // Control word fields
    // ------------------------------------------------------------
    localparam int          PCC_BIT_RUN    = 0;
    localparam int          PCC_BIT_CLR    = 1;
    localparam int          PCC_BIT_OVF    = 2;
    localparam int          PCC_BIT_SPARE  = 3;
    // ------------------------------------------------------------
    // Alarm word fields
    // ------------------------------------------------------------
    localparam int          PCC_BIT_LO_TYP = 0;
    localparam int          PCC_BIT_HI_TYP = 1;
    localparam int          PCC_BIT_LO_CLR = 2;
    localparam int          PCC_BIT_HI_CLR = 3;
    localparam int          PCC_BIT_LO_ST  = 4;
    localparam int          PCC_BIT_HI_ST  = 5;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic        PCC_RST_RUN    = 1'b1;
    localparam logic [31:0] PCC_RST_HILIM  = 32'hffffffff;
    localparam logic [31:0] PCC_RST_LOLIM  = 32'h00000000;

    typedef enum logic {
        PCC_ALM_DISABLE = 1'b0,
        PCC_ALM_LATCH   = 1'b1
    } pcc_alm_type;
endpackage

// ---- rtl/pcc_alarm_if.sv ----
`timescale 1ns/100ps
interface pcc_alarm_if #(parameter int CW = 32);
    logic [CW-1:0] count;
    logic [CW-1:0] limit;
    logic          is_high;
    logic          typ;
    logic          clr;
    logic          status;
    modport core (output count, output limit, output is_high, output typ,
                  output clr, input status);
    modport alarm (input count, input limit, input is_high, input typ,
                   input clr, output status);
endinterface

// ---- rtl/pcc_alarm.sv ----
`timescale 1ns/100ps
module pcc_alarm (
    input  wire logic  pclk,
    input  wire logic  presetn,
    pcc_alarm_if.alarm a
);
    import pcc_pkg::*;

    typedef struct packed {
        logic status;
    } pcc_alarm_st_type;

    pcc_alarm_st_type st_ff;
    pcc_alarm_st_type nxt_st;
    logic             beyond;

    always_comb begin
        nxt_st = st_ff;
        beyond = a.is_high ? (a.count > a.limit) : (a.count < a.limit);
        if (a.typ == PCC_ALM_DISABLE) begin
            nxt_st.status = 1'b0;                                   // [R7]
        end else if (beyond) begin
            nxt_st.status = 1'b1;                                   // [R9]
        end else if (a.clr) begin
            nxt_st.status = 1'b0;                                   // [R9]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign a.status = st_ff.status;
endmodule

// ---- rtl/pcc_counter.sv ----
`timescale 1ns/100ps
// Operation
// [R1] Channel holds an unsigned 32-bit count plus four control/status bits.
// [R2] Run bit resets to 1; 1 counts pulses, 0 halts counting.
// [R3] Clear bit rests 0; writing 1 zeroes the count.
// [R4] Overflow bit reads 0 normally; set by hardware on count overflow.
// [R5] Overflow stays set until software writes 0 to it.
// [R6] Count compared against high and low limits; alarms drive outputs.
// [R7] Disabled alarm type evaluates nothing and never asserts.
// [R8] Momentary type would pulse once; not offered here.
// [R9] Latched alarm holds until software issues a clear-latch command.
// [R10] Only disabled and latched types exist for counter channels.
// [R11] Fourth control bit unused: reads 0, writes ignored.
// [R12] Count increments per rising pulse edge while running; wraps to zero.
module pcc_counter #(
    parameter int CW = 32
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        pulse_in,
    output logic             alarm_hi,
    output logic             alarm_lo,
    output logic             alarm_do
);
    import pcc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [CW-1:0] count;
        logic          run;
        logic          ovf;
        logic [CW-1:0] hilim;
        logic [CW-1:0] lolim;
        logic          hi_typ;
        logic          lo_typ;
        logic          hi_clr;
        logic          lo_clr;
        logic          pulse_d;
        logic [31:0]   rdata;
    } pcc_state_type;

    pcc_state_type st_ff;
    pcc_state_type nxt_st;
    logic          wr_en;
    logic          rd_en;
    logic          rise;
    logic          hit;
    logic          hi_status;
    logic          lo_status;
    wire  [1:0]    alm_st;

    // ------------------------------------------------------------
    // Limit alarms: entry 0 watches the low limit, entry 1 the high
    // ------------------------------------------------------------
    for (genvar g = 0; g < 2; g++) begin : g_alm
        pcc_alarm_if #(.CW(CW)) ifc ();

        assign ifc.count   = st_ff.count;                           // [R6]
        assign ifc.limit   = (g == 1) ? st_ff.hilim : st_ff.lolim;
        assign ifc.is_high = (g == 1);
        assign ifc.typ     = (g == 1) ? st_ff.hi_typ : st_ff.lo_typ;
        assign ifc.clr     = (g == 1) ? st_ff.hi_clr : st_ff.lo_clr;
        assign alm_st[g]   = ifc.status;

        pcc_alarm u_alarm (
            .pclk    (pclk),
            .presetn (presetn),
            .a       (ifc)
        );
    end

    assign hi_status = alm_st[1];
    assign lo_status = alm_st[0];

    assign alarm_hi = hi_status;
    assign alarm_lo = lo_status;
    assign alarm_do = hi_status | lo_status;                        // [R6]

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Zero wait states: every access completes in its first access cycle.
    assign wr_en = psel & penable & pwrite;
    // Read word is captured from the setup cycle on, so prdata leaves a flop
    assign rd_en = psel & ~pwrite;
    assign rise  = pulse_in & ~st_ff.pulse_d;

    always_comb begin
        nxt_st         = st_ff;
        nxt_st.pulse_d = pulse_in;
        nxt_st.hi_clr  = 1'b0;
        nxt_st.lo_clr  = 1'b0;
        hit            = 1'b0;
        if (st_ff.run && rise) begin
            nxt_st.count = st_ff.count + 1'b1;                      // [R12]
        end
        if (wr_en) begin
            unique case (paddr)
                PCC_OFF_COUNT: begin
                    nxt_st.count = pwdata[CW-1:0];
                    hit          = 1'b1;
                end
                PCC_OFF_CTRL: begin
                    nxt_st.run = pwdata[PCC_BIT_RUN];               // [R2]
                    if (pwdata[PCC_BIT_CLR]) begin
                        nxt_st.count = '0;                          // [R3]
                    end
                    if (!pwdata[PCC_BIT_OVF]) begin
                        nxt_st.ovf = 1'b0;                          // [R5]
                    end
                    hit = 1'b1;                                     // [R11]
                end
                PCC_OFF_HILIM: begin
                    nxt_st.hilim = pwdata[CW-1:0];
                    hit          = 1'b1;
                end
                PCC_OFF_LOLIM: begin
                    nxt_st.lolim = pwdata[CW-1:0];
                    hit          = 1'b1;
                end
                PCC_OFF_ALARM: begin
                    // One bit per limit leaves no encoding for momentary
                    nxt_st.lo_typ = pwdata[PCC_BIT_LO_TYP];         // [R10] [R8]
                    nxt_st.hi_typ = pwdata[PCC_BIT_HI_TYP];         // [R10]
                    nxt_st.lo_clr = pwdata[PCC_BIT_LO_CLR];         // [R9]
                    nxt_st.hi_clr = pwdata[PCC_BIT_HI_CLR];         // [R9]
                    hit           = 1'b1;
                end
                default: begin
                    hit = 1'b0;
                end
            endcase
        end
        // Overflow set after the clear so a same-cycle wrap is not lost
        if (st_ff.run && rise && (&st_ff.count)) begin
            nxt_st.ovf = 1'b1;                                      // [R4] [R5]
        end
        if (rd_en) begin
            hit          = 1'b1;
            nxt_st.rdata = 32'h00000000;
            unique case (paddr)
                PCC_OFF_COUNT: nxt_st.rdata[CW-1:0] = st_ff.count;  // [R1]
                PCC_OFF_CTRL: begin
                    nxt_st.rdata[PCC_BIT_RUN]   = st_ff.run;        // [R1]
                    nxt_st.rdata[PCC_BIT_OVF]   = st_ff.ovf;        // [R4]
                    nxt_st.rdata[PCC_BIT_CLR]   = 1'b0;             // [R3]
                    nxt_st.rdata[PCC_BIT_SPARE] = 1'b0;             // [R11]
                end
                PCC_OFF_HILIM: nxt_st.rdata[CW-1:0] = st_ff.hilim;
                PCC_OFF_LOLIM: nxt_st.rdata[CW-1:0] = st_ff.lolim;
                PCC_OFF_ALARM: begin
                    nxt_st.rdata[PCC_BIT_LO_TYP] = st_ff.lo_typ;
                    nxt_st.rdata[PCC_BIT_HI_TYP] = st_ff.hi_typ;
                    nxt_st.rdata[PCC_BIT_LO_ST]  = lo_status;
                    nxt_st.rdata[PCC_BIT_HI_ST]  = hi_status;
                end
                default: hit = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff        <= '0;
            st_ff.run    <= PCC_RST_RUN;                            // [R2]
            st_ff.hilim  <= PCC_RST_HILIM[CW-1:0];
            st_ff.lolim  <= PCC_RST_LOLIM[CW-1:0];
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Read data comes from the word taken at the setup edge
    assign prdata  = st_ff.rdata;

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;
endmodule

// ---- test/pcc_counter_props.sv ----
`timescale 1ns/100ps
module pcc_counter_props
    import pcc_pkg::*;
#(
    parameter int CW = 32
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        pulse_in,
    input wire logic        alarm_hi,
    input wire logic        alarm_lo,
    input wire logic        alarm_do
);
    // ------------------------------------------------------------
    // Shadow of the alarm types, taken from bus writes
    // ------------------------------------------------------------
    typedef struct packed {
        logic hi_en;
        logic lo_en;
    } pcc_chk_type;
    pcc_chk_type st_ff;
    pcc_chk_type nxt_st;
    logic        acc;
    logic        alm_wr;
    assign acc    = psel && penable;
    assign alm_wr = acc && pwrite && (paddr == PCC_OFF_ALARM);
    always_comb begin
        nxt_st = st_ff;
        if (alm_wr) begin
            nxt_st.hi_en = pwdata[PCC_BIT_HI_TYP];
            nxt_st.lo_en = pwdata[PCC_BIT_LO_TYP];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_do; alarm_do == (alarm_hi || alarm_lo); endproperty
    property p_ready; acc |-> pready; endproperty
    property p_unmap; acc && paddr[1:0] == 2'h0 |-> pslverr == (paddr > PCC_OFF_ALARM); endproperty
    property p_spare; acc && !pwrite && paddr == PCC_OFF_CTRL
        |-> prdata[PCC_BIT_SPARE] == 1'b0 && prdata[PCC_BIT_CLR] == 1'b0; endproperty
    // Clear command lands one cycle late, so the write and the cycle after are exempt
    property p_hi_hold; alarm_hi && !alm_wr && !$past(alm_wr) |=> alarm_hi; endproperty
    property p_lo_hold; alarm_lo && !alm_wr && !$past(alm_wr) |=> alarm_lo; endproperty
    property p_hi_dis; !st_ff.hi_en && !$past(st_ff.hi_en) |-> !$rose(alarm_hi); endproperty
    property p_lo_dis; !st_ff.lo_en && !$past(st_ff.lo_en) |-> !$rose(alarm_lo); endproperty
    a_do: assert property (p_do) else $error("alarm output mismatch");
    a_ready: assert property (p_ready) else $error("no ready");
    a_unmap: assert property (p_unmap) else $error("slave error wrong");
    a_spare: assert property (p_spare) else $error("spare or clear reads 1");
    a_hi_hold: assert property (p_hi_hold) else $error("high alarm dropped");
    a_lo_hold: assert property (p_lo_hold) else $error("low alarm dropped");
    a_hi_dis: assert property (p_hi_dis) else $error("disabled high fired");
    a_lo_dis: assert property (p_lo_dis) else $error("disabled low fired");
    c_hi: cover property ($rose(alarm_hi));
    c_lo: cover property ($rose(alarm_lo));
    c_err: cover property (acc && pslverr);
endmodule
bind pcc_counter pcc_counter_props #(.CW(CW)) u_props (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pulse_in, .alarm_hi, .alarm_lo,
    .alarm_do);

// ---- test/pcc_ctl_model.sv ----
`timescale 1ns/100ps
module pcc_ctl_model (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel    = 1'h0;
        penable = 1'h0;
        pwrite  = 1'h0;
        paddr   = 8'h0;
        pwdata  = 32'h0;
    end
    // Request stands until the edge that sees pready high; the answer is taken there
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        logic rdy;
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            rdy = pready;
            rd  = prdata;
            err = pslverr;
        end while (rdy !== 1'h1);
        psel    <= 1'h0;
        penable <= 1'h0;
        pwdata  <= ~d;
        @(posedge pclk);
    endtask
endmodule

// ---- test/tb.sv ----
`timescale 1ns/100ps
module tb;
    import pcc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        pulse_in, alarm_hi, alarm_lo, alarm_do;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    int          miscompares, n_checks, cycles;
    pcc_counter uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .pulse_in, .alarm_hi, .alarm_lo, .alarm_do);
    pcc_ctl_model ctl (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr);
    initial begin
        pclk = 1'h0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            print_verdict();
        end
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ctl.xfer(1'h1, a, d, rd, err);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        ctl.xfer(1'h0, a, 32'h0, rd, err);
        chk(rd, exp);
    endtask
    task automatic pulse(input int n);
        repeat (n) begin
            pulse_in <= 1'h1;
            @(posedge pclk);
            pulse_in <= 1'h0;
            @(posedge pclk);
        end
        @(posedge pclk);
    endtask
    task automatic alm(input logic [31:0] exp);
        repeat (3) @(posedge pclk);
        chk(32'({alarm_do, alarm_lo, alarm_hi}), exp);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rdc(PCC_OFF_CTRL, 32'h1);
        rdc(PCC_OFF_HILIM, 32'hffffffff);
        rdc(PCC_OFF_COUNT, 32'h0);
    endtask
    task automatic t_count;
        pulse(5);
        rdc(PCC_OFF_COUNT, 32'h5);
        wr(PCC_OFF_CTRL, 32'h0);
        pulse(3);
        rdc(PCC_OFF_COUNT, 32'h5);
        wr(PCC_OFF_CTRL, 32'h9);
        rdc(PCC_OFF_CTRL, 32'h1);
        pulse(2);
        rdc(PCC_OFF_COUNT, 32'h7);
        wr(PCC_OFF_CTRL, 32'h3);
        rdc(PCC_OFF_COUNT, 32'h0);
        rdc(PCC_OFF_CTRL, 32'h1);
    endtask
    task automatic t_ovf;
        wr(PCC_OFF_COUNT, 32'hffffffff);
        pulse(1);
        rdc(PCC_OFF_COUNT, 32'h0);
        rdc(PCC_OFF_CTRL, 32'h5);
        wr(PCC_OFF_CTRL, 32'h5);
        rdc(PCC_OFF_CTRL, 32'h5);
        wr(PCC_OFF_CTRL, 32'h1);
        rdc(PCC_OFF_CTRL, 32'h1);
    endtask
    task automatic t_alarm;
        wr(PCC_OFF_CTRL, 32'h0);
        wr(PCC_OFF_HILIM, 32'ha);
        wr(PCC_OFF_LOLIM, 32'h3);
        wr(PCC_OFF_COUNT, 32'h14);
        alm(32'h0);
        wr(PCC_OFF_ALARM, 32'h2);
        alm(32'h5);
        wr(PCC_OFF_COUNT, 32'h5);
        alm(32'h5);
        rdc(PCC_OFF_ALARM, 32'h22);
        wr(PCC_OFF_ALARM, 32'ha);
        alm(32'h0);
        wr(PCC_OFF_COUNT, 32'h0);
        wr(PCC_OFF_ALARM, 32'h1);
        alm(32'h6);
        wr(PCC_OFF_COUNT, 32'h5);
        wr(PCC_OFF_ALARM, 32'h5);
        alm(32'h0);
        ctl.xfer(1'h0, 8'h20, 32'h0, rd, err);
        chk(32'(err), 32'h1);
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        presetn     = 1'h0;
        pulse_in    = 1'h0;
        miscompares = 0;
        n_checks    = 0;
        cycles      = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        t_reset();
        t_count();
        t_ovf();
        t_alarm();
        print_verdict();
    end
endmodule
